// ### rtl/stot_map.svh
// Offsets, field positions, reset values and opcodes of the scan test transceiver
`ifndef STOT_MAP_SVH
`define STOT_MAP_SVH

`define STOT_IR_LEN 8
`define STOT_BSR_LEN 18
`define STOT_BCR_LEN 2

`define STOT_IR_RESET 8'hFF
`define STOT_IR_CAPTURE 8'h81
`define STOT_BCR_RESET 2'h2

`define STOT_OP_EXTEST 8'h00
`define STOT_OP_SAMPLE 8'h01
`define STOT_OP_INTEST 8'h02
`define STOT_OP_HIGHZ 8'h03
`define STOT_OP_CLAMP 8'h04
`define STOT_OP_BCRSCAN 8'h05
`define STOT_OP_RUNT 8'h06
`define STOT_OP_BYPASS 8'hFF

`define STOT_BCR_TOGGLE 2'h0
`define STOT_BCR_PSEUDO_RANDOM_PATTERN_GEN 2'h1
`define STOT_BCR_PSA 2'h2
`define STOT_BCR_IDLE 2'h3

`define STOT_BSR_OE 0
`define STOT_BSR_DIR 1
`define STOT_BSR_A_LSB 2
`define STOT_BSR_A_MSB 9
`define STOT_BSR_B_LSB 10
`define STOT_BSR_B_MSB 17

`define STOT_LFSR_TAPS 8'h8E
`define STOT_LFSR_SEED 8'h01

`define STOT_SYNC_W 22
`define STOT_SYNC_TCK 21
`define STOT_SYNC_TMS 20
`define STOT_SYNC_TDI 19
`define STOT_SYNC_HH 18
`define STOT_SYNC_OE 17
`define STOT_SYNC_DIR 16
`define STOT_SYNC_A_MSB 15
`define STOT_SYNC_A_LSB 8
`define STOT_SYNC_B_MSB 7
`define STOT_SYNC_B_LSB 0

`define STOT_WORD_W 2
`define STOT_WORD_ACT 1
`define STOT_WORD_BIT 0

`endif

// ### rtl/stot_pkg.sv
// Types of the scan test transceiver
package stot_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } stot_tap_type;

  typedef logic [1:0] stot_word_type;

endpackage

// ### rtl/stot_stream_if.sv
// Valid/ready word stream between the scan logic and its output buffer
`timescale 1ns/1ps
interface stot_stream_if import stot_pkg::*; ();
  logic valid;
  logic ready;
  stot_word_type data;

  modport prod (output valid, output data, input ready);
  modport cons (input valid, input data, output ready);
endinterface

// ### rtl/stot_buf.sv
// Two-entry buffer with registered head word
`timescale 1ns/1ps
module stot_buf import stot_pkg::*; (
  input wire logic i_clk,
  input wire logic i_arst_n,
  stot_stream_if.cons in_s,
  stot_stream_if.prod out_s
);

  stot_word_type head_q;
  stot_word_type spare_q;
  logic head_v_q;
  logic spare_v_q;
  wire logic push = in_s.valid & in_s.ready;
  wire logic pop = head_v_q & out_s.ready;

  assign in_s.ready = ~spare_v_q;
  assign out_s.valid = head_v_q;
  assign out_s.data = head_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      head_q <= 2'h0;
      spare_q <= 2'h0;
      head_v_q <= 1'b0;
      spare_v_q <= 1'b0;
    end else if (pop) begin
      if (spare_v_q) begin
        head_q <= spare_q;
        spare_v_q <= 1'b0;
      end else if (push) begin
        head_q <= in_s.data;
      end else begin
        head_v_q <= 1'b0;
      end
    end else if (push) begin
      if (!head_v_q) begin
        head_q <= in_s.data;
        head_v_q <= 1'b1;
      end else begin
        spare_q <= in_s.data;
        spare_v_q <= 1'b1;
      end
    end
  end

endmodule

// ### rtl/stot_transceiver.sv
// Octal bus transceiver with embedded boundary-scan test port
`timescale 1ns/1ps
`include "stot_map.svh"
module stot_transceiver import stot_pkg::*; (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_TCK,
  input wire logic I_TMS,
  input wire logic I_TDI,
  input wire logic I_TMS_HH,
  input wire logic I_OE_N,
  input wire logic I_DIR,
  input wire logic [7:0] I_PORT_A_LINES,
  input wire logic [7:0] I_PORT_B_LINES,
  output logic [7:0] O_PORT_A_LINES,
  output logic O_PORT_A_OE_N,
  output logic [7:0] O_PORT_B_LINES,
  output logic O_PORT_B_OE_N,
  output logic O_TDO,
  output logic O_TDO_OE_N,
  output logic O_TEST_MODE
);

  function automatic logic [7:0] lfsr_step(input logic [7:0] s, input logic [7:0] d);
    logic fb;
    fb = ^(s & `STOT_LFSR_TAPS);
    lfsr_step = {s[6:0], fb} ^ d;
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [`STOT_SYNC_W-1:0] sync1_q;
  logic [`STOT_SYNC_W-1:0] sync2_q;
  wire logic [`STOT_SYNC_W-1:0] pins_raw = {I_TCK, I_TMS, I_TDI, I_TMS_HH, I_OE_N, I_DIR,
                                             I_PORT_A_LINES, I_PORT_B_LINES};

  // Both stages rest at ones, the level a floating pulled-up pin shows
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire logic tck_s = sync2_q[`STOT_SYNC_TCK];
  wire logic tms_s = sync2_q[`STOT_SYNC_TMS];
  wire logic tdi_s = sync2_q[`STOT_SYNC_TDI];
  wire logic hh_s = sync2_q[`STOT_SYNC_HH];
  wire logic oe_n_s = sync2_q[`STOT_SYNC_OE];
  wire logic dir_s = sync2_q[`STOT_SYNC_DIR];
  wire logic [7:0] a_s = sync2_q[`STOT_SYNC_A_MSB:`STOT_SYNC_A_LSB];
  wire logic [7:0] b_s = sync2_q[`STOT_SYNC_B_MSB:`STOT_SYNC_B_LSB];

  //////////////////////////////////////////////////////////////////////////////////////////////
  // TCK edges and TAP controller

  logic tck_q;
  logic push_q;
  stot_tap_type tap_q;
  stot_tap_type tap_d;
  stot_stream_if push_if();
  stot_stream_if pop_if();

  wire logic tck_rise = tck_s & ~tck_q;
  wire logic tck_fall = ~tck_s & tck_q;
  // A rise is only acted on while the TDO buffer can take the word it produces
  wire logic step = tck_rise & push_if.ready;

  always_comb begin
    tap_d = tap_q;
    unique case (tap_q)
      TAP_RESET: tap_d = tms_s ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_d = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_d = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_d = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_d = tms_s ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_d = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_d = tms_s ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_d = tms_s ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_d = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_d = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_d = tms_s ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_d = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_d = tms_s ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: tap_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      tck_q <= 1'b1;
      push_q <= 1'b0;
      tap_q <= TAP_RESET;
    end else begin
      tck_q <= tck_s;
      push_q <= step;
      if (hh_s) begin
        tap_q <= TAP_RESET;
      end else if (step) begin
        tap_q <= tap_d;
      end
    end
  end

  wire logic in_reset = (tap_q == TAP_RESET);
  wire logic cap_dr = step & (tap_q == TAP_CAP_DR);
  wire logic shift_dr = step & (tap_q == TAP_SHIFT_DR);
  wire logic cap_ir = step & (tap_q == TAP_CAP_IR);
  wire logic shift_ir = step & (tap_q == TAP_SHIFT_IR);
  wire logic upd_dr = tck_fall & (tap_q == TAP_UPD_DR);
  wire logic upd_ir = tck_fall & (tap_q == TAP_UPD_IR);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Instruction register and decode

  logic [`STOT_IR_LEN-1:0] ir_sh_q;
  logic [`STOT_IR_LEN-1:0] ir_q;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ir_sh_q <= `STOT_IR_RESET;
      ir_q <= `STOT_IR_RESET;
    end else begin
      if (cap_ir) begin
        ir_sh_q <= `STOT_IR_CAPTURE;
      end else if (shift_ir) begin
        ir_sh_q <= {tdi_s, ir_sh_q[`STOT_IR_LEN-1:1]};
      end
      if (in_reset) begin
        ir_q <= `STOT_IR_RESET;
      end else if (upd_ir) begin
        ir_q <= ir_sh_q;
      end
    end
  end

  // Unknown opcodes fall through to bypass
  wire logic op_extest = (ir_q == `STOT_OP_EXTEST);
  wire logic op_sample = (ir_q == `STOT_OP_SAMPLE);
  wire logic op_intest = (ir_q == `STOT_OP_INTEST);
  wire logic op_highz = (ir_q == `STOT_OP_HIGHZ);
  wire logic op_clamp = (ir_q == `STOT_OP_CLAMP);
  wire logic op_runt = (ir_q == `STOT_OP_RUNT);
  wire logic sel_bsr = op_extest | op_sample | op_intest | op_runt;
  wire logic sel_bcr = (ir_q == `STOT_OP_BCRSCAN);
  wire logic test_mode = ~in_reset & (op_extest | op_intest | op_highz | op_clamp | op_runt);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Data registers

  logic [`STOT_BSR_LEN-1:0] bsr_sh_q;
  logic [`STOT_BSR_LEN-1:0] bsr_sh_d;
  logic [`STOT_BSR_LEN-1:0] bsr_upd_q;
  logic [`STOT_BSR_LEN-1:0] bsr_upd_d;
  logic [`STOT_BCR_LEN-1:0] bcr_sh_q;
  logic [`STOT_BCR_LEN-1:0] bcr_q;
  logic byp_q;

  wire logic dir_t = bsr_upd_q[`STOT_BSR_DIR];
  wire logic [7:0] sh_a = bsr_sh_q[`STOT_BSR_A_MSB:`STOT_BSR_A_LSB];
  wire logic [7:0] sh_b = bsr_sh_q[`STOT_BSR_B_MSB:`STOT_BSR_B_LSB];
  wire logic [7:0] upd_a = bsr_upd_q[`STOT_BSR_A_MSB:`STOT_BSR_A_LSB];
  wire logic [7:0] upd_b = bsr_upd_q[`STOT_BSR_B_MSB:`STOT_BSR_B_LSB];
  // Side that receives in test mode, and the side that drives
  wire logic [7:0] in_pins = dir_t ? a_s : b_s;
  wire logic [7:0] in_cells = dir_t ? sh_a : sh_b;
  wire logic [7:0] out_upd = dir_t ? upd_b : upd_a;
  wire logic [7:0] sig_next = lfsr_step(in_cells, in_pins);
  wire logic [7:0] pseudo_random_pattern_gen_raw = lfsr_step(out_upd, 8'h00);
  wire logic [7:0] pseudo_random_pattern_gen_next = (pseudo_random_pattern_gen_raw == 8'h00) ? `STOT_LFSR_SEED : pseudo_random_pattern_gen_raw;
  // Self-test runs only in Run-Test/Idle under the run instruction
  wire logic run_tick = step & (tap_q == TAP_IDLE) & op_runt;
  wire logic run_psa = run_tick & (bcr_q == `STOT_BCR_PSA);
  wire logic run_pseudo_random_pattern_gen = run_tick & (bcr_q == `STOT_BCR_PSEUDO_RANDOM_PATTERN_GEN);
  wire logic run_toggle = run_tick & (bcr_q == `STOT_BCR_TOGGLE);
  wire logic [7:0] in_new = run_psa ? sig_next : in_pins;
  wire logic [7:0] out_new = run_pseudo_random_pattern_gen ? pseudo_random_pattern_gen_next : ~out_upd;

  always_comb begin
    bsr_sh_d = bsr_sh_q;
    if (cap_dr & sel_bsr) begin
      bsr_sh_d = {b_s, a_s, dir_s, oe_n_s};
    end else if (shift_dr & sel_bsr) begin
      bsr_sh_d = {tdi_s, bsr_sh_q[`STOT_BSR_LEN-1:1]};
    end else if (run_psa | run_toggle) begin
      if (dir_t) begin
        bsr_sh_d[`STOT_BSR_A_MSB:`STOT_BSR_A_LSB] = in_new;
      end else begin
        bsr_sh_d[`STOT_BSR_B_MSB:`STOT_BSR_B_LSB] = in_new;
      end
    end
  end

  always_comb begin
    bsr_upd_d = bsr_upd_q;
    if (upd_dr & sel_bsr) begin
      bsr_upd_d = bsr_sh_q;
    end else if (run_pseudo_random_pattern_gen | run_toggle) begin
      if (dir_t) begin
        bsr_upd_d[`STOT_BSR_B_MSB:`STOT_BSR_B_LSB] = out_new;
      end else begin
        bsr_upd_d[`STOT_BSR_A_MSB:`STOT_BSR_A_LSB] = out_new;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      bsr_sh_q <= 18'h3_FFFF;
      bsr_upd_q <= 18'h3_FFFF;
    end else begin
      bsr_sh_q <= bsr_sh_d;
      bsr_upd_q <= bsr_upd_d;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      bcr_sh_q <= `STOT_BCR_RESET;
      bcr_q <= `STOT_BCR_RESET;
      byp_q <= 1'b0;
    end else begin
      if (cap_dr & sel_bcr) begin
        bcr_sh_q <= bcr_q;
      end else if (shift_dr & sel_bcr) begin
        bcr_sh_q <= {tdi_s, bcr_sh_q[`STOT_BCR_LEN-1]};
      end
      if (in_reset) begin
        bcr_q <= `STOT_BCR_RESET;
      end else if (upd_dr & sel_bcr) begin
        bcr_q <= bcr_sh_q;
      end
      if (cap_dr) begin
        byp_q <= 1'b0;
      end else if (shift_dr) begin
        byp_q <= tdi_s;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // TDO path through the two-entry buffer

  wire logic shifting = (tap_q == TAP_SHIFT_DR) | (tap_q == TAP_SHIFT_IR);
  wire logic dr_lsb = sel_bsr ? bsr_sh_q[0] : (sel_bcr ? bcr_sh_q[0] : byp_q);
  wire logic tdo_bit = (tap_q == TAP_SHIFT_IR) ? ir_sh_q[0] : dr_lsb;

  // Word is formed the cycle after a rise, once the shift registers have settled
  assign push_if.valid = push_q;
  assign push_if.data = {shifting, tdo_bit};
  assign pop_if.ready = tck_fall;

  stot_buf u_buf (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .in_s(push_if),
    .out_s(pop_if)
  );

  wire logic tdo_pop = pop_if.valid & tck_fall;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_TDO <= 1'b1;
      O_TDO_OE_N <= 1'b1;
    end else if (tdo_pop) begin
      O_TDO <= pop_if.data[`STOT_WORD_ACT] ? pop_if.data[`STOT_WORD_BIT] : 1'b1;
      O_TDO_OE_N <= ~pop_if.data[`STOT_WORD_ACT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Transceiver data path

  wire logic norm_b = ~oe_n_s & dir_s;
  wire logic norm_a = ~oe_n_s & ~dir_s;
  wire logic test_on = ~bsr_upd_q[`STOT_BSR_OE] & ~op_highz;
  wire logic test_b = test_on & dir_t;
  wire logic test_a = test_on & ~dir_t;
  // Normal path ignores all test state except the mode decode
  wire logic drive_b = test_mode ? test_b : norm_b;
  wire logic drive_a = test_mode ? test_a : norm_a;
  wire logic [7:0] val_b = test_mode ? upd_b : a_s;
  wire logic [7:0] val_a = test_mode ? upd_a : b_s;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PORT_A_LINES <= 8'hFF;
      O_PORT_B_LINES <= 8'hFF;
      O_PORT_A_OE_N <= 1'b1;
      O_PORT_B_OE_N <= 1'b1;
      O_TEST_MODE <= 1'b0;
    end else begin
      O_PORT_A_LINES <= val_a;
      O_PORT_B_LINES <= val_b;
      O_PORT_A_OE_N <= ~drive_a;
      O_PORT_B_OE_N <= ~drive_b;
      O_TEST_MODE <= test_mode;
    end
  end

endmodule

// ### tb/stot_transceiver_checker.sv
// Port assertions of the scan test transceiver
`timescale 1ns/1ps
module stot_transceiver_checker (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_TCK,
  input wire logic I_TMS_HH,
  input wire logic I_OE_N,
  input wire logic I_DIR,
  input wire logic [7:0] I_PORT_A_LINES,
  input wire logic [7:0] O_PORT_B_LINES,
  input wire logic O_PORT_A_OE_N,
  input wire logic O_PORT_B_OE_N,
  input wire logic O_TDO,
  input wire logic O_TDO_OE_N,
  input wire logic O_TEST_MODE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  ////////////////////////////////////////////////////////////////
  // Normal-mode pins held long enough to cross the synchronisers
  sequence s_nrm(logic d);
    (!I_OE_N && I_DIR == d && !O_TEST_MODE)[*5];
  endsequence
  sequence s_iso;
    (I_OE_N && !O_TEST_MODE)[*5];
  endsequence
  property p_a2b;
    s_nrm(1'b1) |-> !O_PORT_B_OE_N && O_PORT_A_OE_N;
  endproperty
  property p_b2a;
    s_nrm(1'b0) |-> !O_PORT_A_OE_N && O_PORT_B_OE_N;
  endproperty
  property p_iso;
    s_iso |-> O_PORT_A_OE_N && O_PORT_B_OE_N;
  endproperty
  property p_a2b_data;
    (!I_OE_N && I_DIR && !O_TEST_MODE && $stable(I_PORT_A_LINES))[*5] |-> O_PORT_B_LINES == I_PORT_A_LINES;
  endproperty
  property p_tdo_idle;
    O_TDO_OE_N |-> O_TDO;
  endproperty
  // Tdo and its enable move only after a tck fall has crossed the synchroniser
  property p_tdo_fall;
    $changed({O_TDO, O_TDO_OE_N}) |-> !$past(I_TCK, 3);
  endproperty
  property p_hh;
    I_TMS_HH[*6] |-> !O_TEST_MODE && O_TDO_OE_N;
  endproperty
  property p_rst;
    $rose(I_ARST_N) |-> !O_TEST_MODE && O_PORT_A_OE_N && O_PORT_B_OE_N;
  endproperty
  ////////////////////////////////////////////////////////////////
  a_a2b: assert property (p_a2b) else $error("a to b enables wrong");
  a_b2a: assert property (p_b2a) else $error("b to a enables wrong");
  a_iso: assert property (p_iso) else $error("isolation broken");
  a_a2b_data: assert property (p_a2b_data) else $error("b value wrong");
  a_tdo_idle: assert property (p_tdo_idle) else $error("idle tdo not high");
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off a fall");
  a_hh: assert property (p_hh) else $error("double high did not reset");
  a_rst: assert property (p_rst) else $error("power-up state wrong");
endmodule
bind stot_transceiver stot_transceiver_checker i_stot_transceiver_checker (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
  .I_TCK(I_TCK), .I_TMS_HH(I_TMS_HH), .I_OE_N(I_OE_N), .I_DIR(I_DIR), .I_PORT_A_LINES(I_PORT_A_LINES),
  .O_PORT_B_LINES(O_PORT_B_LINES), .O_PORT_A_OE_N(O_PORT_A_OE_N), .O_PORT_B_OE_N(O_PORT_B_OE_N),
  .O_TDO(O_TDO), .O_TDO_OE_N(O_TDO_OE_N), .O_TEST_MODE(O_TEST_MODE));

// ### tb/stot_tap_master.sv
// Test bus controller model driving the scan port
`timescale 1ns/1ps
module stot_tap_master (
  input wire logic i_clk,
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // One 80 ns test clock; tdo is read late in the high phase
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(negedge i_clk);
    o_tck = 1'b1;
    repeat (4) @(negedge i_clk);
    tdo = i_tdo;
    o_tck = 1'b0;
  endtask
  // Idle to idle scan, lsb first; tdi released high outside the shift
  task automatic scan(input logic ir, input logic [17:0] din, input int n, output logic [17:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b1, t);
    if (ir) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    step(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask
endmodule

// ### tb/scan_test_octal_transceiver_test.sv
// Self-checking bench of the scan test transceiver
`timescale 1ns/1ps
module scan_test_octal_transceiver_test;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hh = 1'b0;
  logic oe_n = 1'b1;
  logic dir = 1'b1;
  logic [7:0] ext_a = 8'hFF;
  logic [7:0] ext_b = 8'hFF;
  logic [15:0] lfsr = 16'h0008;
  logic [17:0] dout;
  logic [7:0] v;
  logic [7:0] oa;
  logic [7:0] ob;
  logic oa_n, ob_n, tdo, tdo_n, tm, tck, tms, tdi;
  wire logic [7:0] pin_a = oa_n ? ext_a : oa;
  wire logic [7:0] pin_b = ob_n ? ext_b : ob;
  int fails = 0;
  int checked = 0;
  always #5 clk = ~clk;
  stot_transceiver i_stot_transceiver (.I_CLK(clk), .I_ARST_N(arst_n), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi),
    .I_TMS_HH(hh), .I_OE_N(oe_n), .I_DIR(dir), .I_PORT_A_LINES(pin_a), .I_PORT_B_LINES(pin_b),
    .O_PORT_A_LINES(oa), .O_PORT_A_OE_N(oa_n), .O_PORT_B_LINES(ob), .O_PORT_B_OE_N(ob_n), .O_TDO(tdo),
    .O_TDO_OE_N(tdo_n), .O_TEST_MODE(tm));
  // Tdo pin has a pull-up
  stot_tap_master i_stot_tap_master (.i_clk(clk), .i_tdo(tdo_n | tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Next pattern of the output-side generator; the all-zero state is skipped
  function automatic logic [7:0] pseudo_random_pattern_gen(logic [7:0] x);
    logic [7:0] y;
    y = {x[6:0], ^(x & 8'h8E)};
    return (y == 8'h00) ? 8'h01 : y;
  endfunction
  function automatic logic [9:0] path(logic o, logic d, logic [7:0] a, logic [7:0] b);
    return o ? 10'h300 : d ? {2'b10, a} : {2'b01, b};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask
  task automatic finish_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ir(input logic [7:0] op);
    i_stot_tap_master.scan(1'b1, {10'h000, op}, 8, dout);
    chk(dout[7:0], 8'h81);
    repeat (6) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge clk);
    fails++;
    finish_test();
  end
  initial begin
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({tm, oa_n, ob_n, tdo_n, tdo}, 5'h0F);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      lfsr = nxt(lfsr);
      {oe_n, dir, ext_a} = lfsr[9:0];
      ext_b = lfsr[15:8];
      if (i < 2) {oe_n, dir, ext_a, ext_b} = {1'b0, i[0], 8'h00, 8'hFF};
      repeat (6) @(negedge clk);
      chk({oa_n, ob_n, oe_n ? 8'h00 : dir ? ob : oa}, path(oe_n, dir, ext_a, ext_b));
    end
    $display("test normal path done");
    {oe_n, dir, ext_a, v} = {2'b01, lfsr};
    repeat (6) @(negedge clk);
    i_stot_tap_master.step(1'b0, 1'b1, dout[0]);
    ir(8'h01);
    i_stot_tap_master.scan(1'b0, {v, 8'h00, 2'b10}, 18, dout);
    chk(dout, {ext_a, ext_a, 2'b10});
    chk({tm, ob}, {1'b0, ext_a});
    $display("test sample done");
    ir(8'h00);
    ext_a = ~ext_a;
    repeat (6) @(negedge clk);
    chk({tm, oa_n, ob_n, ob}, {3'b110, v});
    ir(8'h03);
    chk({tm, oa_n, ob_n}, 3'h7);
    $display("test extest done");
    hh = 1'b1;
    repeat (8) @(negedge clk);
    hh = 1'b0;
    repeat (6) @(negedge clk);
    chk({tm, ob_n, ob}, {2'b00, ext_a});
    i_stot_tap_master.step(1'b0, 1'b1, dout[0]);
    i_stot_tap_master.scan(1'b0, 18'h0_0005, 3, dout);
    chk(dout[2:0], 3'b010);
    ir(8'h05);
    i_stot_tap_master.scan(1'b0, 18'h0_0003, 2, dout);
    chk(dout[1:0], 2'b10);
    $display("test reset values done");
    i_stot_tap_master.scan(1'b0, 18'h0_0000, 2, dout);
    chk(dout[1:0], 2'b11);
    ir(8'h06);
    i_stot_tap_master.step(1'b0, 1'b1, dout[0]);
    repeat (6) @(negedge clk);
    chk({tm, ob_n, ob}, {2'b10, ~v});
    ir(8'h05);
    i_stot_tap_master.scan(1'b0, 18'h0_0001, 2, dout);
    chk(dout[1:0], 2'b00);
    ir(8'h06);
    i_stot_tap_master.step(1'b0, 1'b1, dout[0]);
    repeat (6) @(negedge clk);
    chk({tm, ob_n, ob}, {2'b10, pseudo_random_pattern_gen(v)});
    $display("test self-test done");
    finish_test();
  end
endmodule
